// ==== core/lsbt_pkg.sv ====
// constants, encodings and period lookups for the sink blink timer
package lsbt_pkg;

    localparam logic [7:0] SINK_ENABLE_ADDR     = 8'h10;
    localparam logic [7:0] ON_TIME_ADDR         = 8'h11;
    localparam logic [7:0] OFFTIME_ADDR         = 8'h12;
    localparam logic [7:0] FADE_ADDR            = 8'h13;

    localparam logic [7:0] SINK_ENABLE_RESET    = 8'h00;
    localparam logic [7:0] ON_TIME_RESET        = 8'h00;
    localparam logic [7:0] OFFTIME_RESET        = 8'h00;
    localparam logic [7:0] FADE_RESET           = 8'h00;

    localparam int         ON_FIELD_LSB         = 6;
    localparam int         OFF_FIELD_WIDTH      = 2;
    localparam int         FADE_OUT_LSB         = 4;
    localparam int         FADE_IN_LSB          = 0;
    localparam int         FADE_FIELD_WIDTH     = 4;
    localparam int         CHANNELS             = 4;

    localparam logic [1:0] OFF_DISABLED         = 2'h0;
    localparam logic [3:0] FADE_DISABLED        = 4'h0;
    localparam logic [3:0] FADE_KNEE_CODE       = 4'ha;

    localparam int         CLK_PERIOD_NS        = 100;
    localparam int         TICK_MS              = 50;
    localparam int         TICK_CYCLES_DEFAULT  = TICK_MS * 1000000 / CLK_PERIOD_NS;

    localparam int         ON_MS_0              = 200;
    localparam int         ON_MS_1              = 600;
    localparam int         ON_MS_2              = 800;
    localparam int         ON_MS_3              = 1200;
    localparam int         OFF_MS_1             = 600;
    localparam int         OFF_MS_2             = 1200;
    localparam int         OFF_MS_3             = 1800;
    localparam int         FADE_LOW_STEP_MS     = 300;
    localparam int         FADE_HIGH_BASE_MS    = 3000;
    localparam int         FADE_HIGH_STEP_MS    = 500;

    typedef enum logic [1:0] {
        LSBT_IDLE = 2'b00,
        LSBT_ON   = 2'b01,
        LSBT_OFF  = 2'b10
    } lsbt_state_t;

    function automatic logic [7:0] on_ticks(input logic [1:0] code);
        int ms;
        case (code)
            2'h0:    ms = ON_MS_0;
            2'h1:    ms = ON_MS_1;
            2'h2:    ms = ON_MS_2;
            default: ms = ON_MS_3;
        endcase
        return 8'(ms / TICK_MS);
    endfunction

    function automatic logic [7:0] off_ticks(input logic [1:0] code);
        int ms;
        case (code)
            2'h1:    ms = OFF_MS_1;
            2'h2:    ms = OFF_MS_2;
            2'h3:    ms = OFF_MS_3;
            default: ms = 0;
        endcase
        return 8'(ms / TICK_MS);
    endfunction

    function automatic logic [7:0] fade_ticks(input logic [3:0] code);
        int ms;
        ms = 0;
        if (code <= FADE_KNEE_CODE) begin
            ms = int'(code) * FADE_LOW_STEP_MS;
        end else begin
            ms = FADE_HIGH_BASE_MS + (int'(code) - int'(FADE_KNEE_CODE)) * FADE_HIGH_STEP_MS;
        end
        return 8'(ms / TICK_MS);
    endfunction

endpackage

// ==== core/lsbt_channel.sv ====
// one sink's on/off blink sequencer with fade ramp timing
`timescale 1ns/1ps
module lsbt_channel (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       ce,
    input  wire logic       tick,
    input  wire logic       enable,
    input  wire logic [1:0] off_code,
    input  wire logic [1:0] on_code,
    input  wire logic [3:0] fade_in_code,
    input  wire logic [3:0] fade_out_code,
    output logic            sink_on,
    output logic            ramp
);

    lsbt_pkg::lsbt_state_t state;
    lsbt_pkg::lsbt_state_t next_state;
    logic [7:0]            cnt;
    logic [7:0]            next_cnt;
    logic [7:0]            ramp_cnt;
    logic [7:0]            next_ramp_cnt;
    logic                  next_sink_on;
    logic                  next_ramp;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_state    = state;
        next_cnt      = cnt;
        next_ramp_cnt = ramp_cnt;
        next_sink_on  = sink_on;
        if (tick && ramp_cnt != 8'h00) begin
            next_ramp_cnt = ramp_cnt - 8'h01;
        end
        if (!enable) begin
            // off at once, no fade: disable must win over timing
            next_state    = lsbt_pkg::LSBT_IDLE;
            next_cnt      = 8'h00;
            next_ramp_cnt = 8'h00;
            next_sink_on  = 1'b0;
        end else begin
            case (state)
                lsbt_pkg::LSBT_IDLE: begin
                    // sequence starts on enable edge, so one write aligns sinks
                    next_state    = lsbt_pkg::LSBT_ON;
                    next_cnt      = 8'h00;
                    next_ramp_cnt = lsbt_pkg::fade_ticks(fade_in_code);
                    next_sink_on  = 1'b1;
                end
                lsbt_pkg::LSBT_ON: begin
                    if (off_code == lsbt_pkg::OFF_DISABLED) begin
                        next_cnt = 8'h00;
                    end else if (tick) begin
                        if (cnt + 8'h01 >= lsbt_pkg::on_ticks(on_code)) begin
                            next_state    = lsbt_pkg::LSBT_OFF;
                            next_cnt      = 8'h00;
                            next_ramp_cnt = lsbt_pkg::fade_ticks(fade_out_code);
                            next_sink_on  = 1'b0;
                        end else begin
                            next_cnt = cnt + 8'h01;
                        end
                    end
                end
                lsbt_pkg::LSBT_OFF: begin
                    if (off_code == lsbt_pkg::OFF_DISABLED) begin
                        // code cleared mid-blink: back to steady on
                        next_state   = lsbt_pkg::LSBT_ON;
                        next_cnt     = 8'h00;
                        next_sink_on = 1'b1;
                    end else if (tick) begin
                        if (cnt + 8'h01 >= lsbt_pkg::off_ticks(off_code)) begin
                            next_state    = lsbt_pkg::LSBT_ON;
                            next_cnt      = 8'h00;
                            next_ramp_cnt = lsbt_pkg::fade_ticks(fade_in_code);
                            next_sink_on  = 1'b1;
                        end else begin
                            next_cnt = cnt + 8'h01;
                        end
                    end
                end
                default: begin
                    next_state   = lsbt_pkg::LSBT_IDLE;
                    next_cnt     = 8'h00;
                    next_sink_on = 1'b0;
                end
            endcase
        end
        next_ramp = (next_ramp_cnt != 8'h00);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state    <= lsbt_pkg::LSBT_IDLE;
            cnt      <= 8'h00;
            ramp_cnt <= 8'h00;
            sink_on  <= 1'b0;
            ramp     <= 1'b0;
        end else if (ce) begin
            state    <= next_state;
            cnt      <= next_cnt;
            ramp_cnt <= next_ramp_cnt;
            sink_on  <= next_sink_on;
            ramp     <= next_ramp;
        end
    end

endmodule

// ==== core/lsbt_top.sv ====
// blink timer top: register file, shared time base, four channel sequencers
//
// How it works
// - channel 4 off code in bits 7:6
// - channel 3 off code in bits 5:4
// - channel 2 off code in bits 3:2
// - channel 1 off code in bits 1:0
// - code 00: sink steadily on while enabled
// - otherwise alternate off period and on period
// - sinks enabled together start sequences together
// - fade register: out rate high, in rate low
// - shared on code picks 0.2/0.6/0.8/1.2 s
// - enable bit zero forces sink off
// - fade codes: 0000 off, else 0.3-5.5 s
`timescale 1ns/1ps
module lsbt_top #(
    parameter int TICK_CYCLES = lsbt_pkg::TICK_CYCLES_DEFAULT
) (
    input  wire logic       REF_CLK,
    input  wire logic       RST,
    input  wire logic       CE,
    input  wire logic       REG_WR,
    input  wire logic       REG_RD,
    input  wire logic [7:0] REG_ADDR,
    input  wire logic [7:0] REG_WDATA,
    output logic      [7:0] REG_RDATA,
    output logic      [3:0] SINK_ON,
    output logic      [3:0] SINK_RAMP
);

    logic [7:0]  sink_enable;
    logic [7:0]  next_sink_enable;
    logic [7:0]  on_time;
    logic [7:0]  next_on_time;
    logic [7:0]  sink_offtime_ch1_to_4;
    logic [7:0]  next_sink_offtime_ch1_to_4;
    logic [7:0]  sink_fade_rates;
    logic [7:0]  next_sink_fade_rates;
    logic [7:0]  next_rdata;
    logic [19:0] tick_cnt;
    logic [19:0] next_tick_cnt;
    logic        tick;
    logic        next_tick;
    logic [1:0]  shared_on_period;
    logic [3:0]  fade_out_rate;
    logic [3:0]  fade_in_rate;

    ////////////////////////////////////////////////////////////////////////////
    // register file
    always_comb begin
        next_sink_enable           = sink_enable;
        next_on_time               = on_time;
        next_sink_offtime_ch1_to_4 = sink_offtime_ch1_to_4;
        next_sink_fade_rates       = sink_fade_rates;
        next_rdata                 = REG_RDATA;
        if (REG_WR) begin
            case (REG_ADDR)
                lsbt_pkg::SINK_ENABLE_ADDR: next_sink_enable = REG_WDATA;
                lsbt_pkg::ON_TIME_ADDR:     next_on_time = REG_WDATA;
                lsbt_pkg::OFFTIME_ADDR:     next_sink_offtime_ch1_to_4 = REG_WDATA;
                lsbt_pkg::FADE_ADDR:        next_sink_fade_rates = REG_WDATA;
                default:                    next_sink_enable = sink_enable;
            endcase
        end
        if (REG_RD) begin
            case (REG_ADDR)
                lsbt_pkg::SINK_ENABLE_ADDR: next_rdata = sink_enable;
                lsbt_pkg::ON_TIME_ADDR:     next_rdata = on_time;
                lsbt_pkg::OFFTIME_ADDR:     next_rdata = sink_offtime_ch1_to_4;
                lsbt_pkg::FADE_ADDR:        next_rdata = sink_fade_rates;
                default:                    next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            sink_enable           <= lsbt_pkg::SINK_ENABLE_RESET;
            on_time               <= lsbt_pkg::ON_TIME_RESET;
            sink_offtime_ch1_to_4 <= lsbt_pkg::OFFTIME_RESET;
            sink_fade_rates       <= lsbt_pkg::FADE_RESET;
            REG_RDATA             <= 8'h00;
        end else if (CE) begin
            sink_enable           <= next_sink_enable;
            on_time               <= next_on_time;
            sink_offtime_ch1_to_4 <= next_sink_offtime_ch1_to_4;
            sink_fade_rates       <= next_sink_fade_rates;
            REG_RDATA             <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // free-running time base; channels share it, so one write keeps them in step
    always_comb begin
        next_tick     = 1'b0;
        next_tick_cnt = tick_cnt + 20'h00001;
        if (tick_cnt >= 20'(TICK_CYCLES - 1)) begin
            next_tick_cnt = 20'h00000;
            next_tick     = 1'b1;
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            tick_cnt <= 20'h00000;
            tick     <= 1'b0;
        end else if (CE) begin
            tick_cnt <= next_tick_cnt;
            tick     <= next_tick;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // field extraction; bits 5:0 of the on-time register serve unbuilt channels
    assign shared_on_period = on_time[lsbt_pkg::ON_FIELD_LSB +: 2];
    assign fade_out_rate    = sink_fade_rates[lsbt_pkg::FADE_OUT_LSB +: 4];
    assign fade_in_rate     = sink_fade_rates[lsbt_pkg::FADE_IN_LSB +: 4];

    for (genvar ch = 0; ch < lsbt_pkg::CHANNELS; ch++) begin : g_ch
        // channel n off code at bits 2n+1:2n
        lsbt_channel u_ch (
            .clk           (REF_CLK),
            .rst           (RST),
            .ce            (CE),
            .tick          (tick),
            .enable        (sink_enable[ch]),
            .off_code      (sink_offtime_ch1_to_4[ch*lsbt_pkg::OFF_FIELD_WIDTH +: 2]),
            .on_code       (shared_on_period),
            .fade_in_code  (fade_in_rate),
            .fade_out_code (fade_out_rate),
            .sink_on       (SINK_ON[ch]),
            .ramp          (SINK_RAMP[ch])
        );
    end

endmodule

// ==== verif/lsbt_led_model.sv ====
// led model: lengths of the last lit and dark phase of each sink
`timescale 1ns/1ps
module lsbt_led_model (
    input wire logic       clk,
    input wire logic [3:0] sink_on
);
    int         cyc = 0;
    int         last[4];
    int         lit_len[4];
    int         dark_len[4];
    logic [3:0] prev = 4'h0;
    ////////////////////////////////////////
    // leds only sink current, so nothing is driven back into the block
    always @(posedge clk) begin
        cyc++;
        for (int i = 0; i < 4; i++) begin
            if (sink_on[i] !== prev[i]) begin
                if (prev[i] === 1'b1) begin
                    lit_len[i] = cyc - last[i];
                end else begin
                    dark_len[i] = cyc - last[i];
                end
                last[i] = cyc;
            end
        end
        prev = sink_on;
    end
endmodule

// ==== verif/lsbt_top_asserts.sv ====
// checker: port assertions of the blink timer top
`timescale 1ns/1ps
module lsbt_top_asserts #(
    parameter int TICK_CYCLES = 4
) (
    input wire logic       REF_CLK,
    input wire logic       RST,
    input wire logic       CE,
    input wire logic       REG_WR,
    input wire logic       REG_RD,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic [7:0] REG_RDATA,
    input wire logic [3:0] SINK_ON,
    input wire logic [3:0] SINK_RAMP
);
    localparam int MAX_ON  = 24 * TICK_CYCLES + 4;
    localparam int MAX_OFF = 36 * TICK_CYCLES + 4;
    logic [3:0] en_q;
    logic [3:0] en_d;
    logic [7:0] off_q;
    int         on_run;
    int         off_run;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);
    ////////////////////////////////////////
    // shadows lag like the sinks, so counters see only real phases
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            en_q    <= 4'h0;
            en_d    <= 4'h0;
            off_q   <= 8'h00;
            on_run  <= 0;
            off_run <= 0;
        end else if (CE) begin
            en_d    <= en_q;
            if (REG_WR && REG_ADDR == 8'h10) en_q <= REG_WDATA[3:0];
            if (REG_WR && REG_ADDR == 8'h12) off_q <= REG_WDATA;
            on_run  <= (SINK_ON[0] && en_q[0] && off_q[1:0] != 2'h0) ? on_run + 1 : 0;
            off_run <= (!SINK_ON[0] && en_q[0] && en_d[0]) ? off_run + 1 : 0;
        end
    end
    ////////////////////////////////////////
    AST_WR_RD: assert property ((CE && REG_WR && REG_ADDR inside {[8'h10:8'h13]}) ##1 !REG_WR
        ##1 (CE && REG_RD && !REG_WR && REG_ADDR == $past(REG_ADDR, 2))
        |=> REG_RDATA == $past(REG_WDATA, 3)) else $error("readback mismatch");
    AST_RD_UNMAPPED: assert property (CE && REG_RD && !(REG_ADDR inside {[8'h10:8'h13]})
        |=> REG_RDATA == 8'h00) else $error("unmapped read not zero");
    AST_RD_HOLD: assert property (!(CE && REG_RD) |=> $stable(REG_RDATA))
        else $error("read data moved");
    AST_JOINT_START: assert property ((CE && REG_WR && REG_ADDR == 8'h10
        && REG_WDATA[3:0] == 4'hf && en_q == 4'h0 && SINK_ON == 4'h0) ##1 CE
        |=> SINK_ON == 4'hf)
        else $error("sinks did not start together");
    AST_NEEDS_EN: assert property ((SINK_ON & ~en_d) == 4'h0) else $error("sink on while off");
    AST_RAMP_EN: assert property ((SINK_RAMP & ~en_d) == 4'h0) else $error("ramp while off");
    AST_ON_LIMIT: assert property (on_run <= MAX_ON) else $error("on phase too long");
    AST_OFF_LIMIT: assert property (off_run <= MAX_OFF) else $error("off phase too long");
    for (genvar i = 0; i < 4; i++) begin : g_ch
        AST_STEADY: assert property ((CE && en_q[i] && off_q[2*i+:2] == 2'h0) [*3]
            |-> SINK_ON[i]) else $error("sink not steady");
    end
    cover property ($rose(SINK_ON[0]));
    cover property ($fell(SINK_ON[0]) && en_q[0]);
    cover property ($rose(SINK_RAMP[0]));
endmodule
bind lsbt_top lsbt_top_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.REF_CLK(REF_CLK), .RST(RST),
    .CE(CE), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_RDATA(REG_RDATA), .SINK_ON(SINK_ON), .SINK_RAMP(SINK_RAMP));

// ==== verif/lsbt_top_tb.sv ====
// bench for the sink blink timer top
`timescale 1ns/1ps
module lsbt_top_tb;
    localparam int TC = 4;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       ce = 1'b0;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic [3:0] sink_on;
    logic [3:0] ramp;
    int         err_count = 0;
    int         n_checks = 0;
    int         on_t[4] = '{4, 12, 16, 24};
    int         off_t[4] = '{0, 12, 24, 36};
    always #50 clk = ~clk;
    lsbt_top #(.TICK_CYCLES(TC)) dut (.REF_CLK(clk), .RST(rst), .CE(ce), .REG_WR(wr), .REG_RD(rd),
        .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .SINK_ON(sink_on), .SINK_RAMP(ramp));
    lsbt_led_model leds (.clk(clk), .sink_on(sink_on));
    ////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // idle edge after each write so strobes never toggle twice in one step
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask
    task automatic test_regs();
        logic [7:0] d;
        for (int a = 16; a < 20; a++) begin
            rd_reg(8'(a), d);
            chk("reset value", 8'h00, d);
            wr_reg(8'(a), 8'(8'ha5 + a));
            rd_reg(8'(a), d);
            chk("readback", 8'(8'ha5 + a), d);
        end
        wr_reg(8'h14, 8'hff);
        rd_reg(8'h14, d);
        chk("unmapped read", 8'h00, d);
        ce <= 1'b0;
        wr_reg(8'h12, 8'h00);
        ce <= 1'b1;
        rd_reg(8'h12, d);
        chk("frozen write", 8'hb7, d);
        for (int a = 16; a < 20; a++) wr_reg(8'(a), 8'h00);
        $display("test regs done");
    endtask
    task automatic test_steady();
        wr_reg(8'h10, 8'h0f);
        repeat (4) begin
            @(negedge clk);
            chk("steady sinks", 4'hf, sink_on);
            chk("no ramp", 4'h0, ramp);
            repeat (9 * TC) @(posedge clk);
        end
        wr_reg(8'h10, 8'h00);
        @(negedge clk);
        chk("disabled sinks", 4'h0, sink_on);
        @(posedge clk);
        $display("test steady done");
    endtask
    task automatic test_blink();
        logic [7:0] pat[2] = '{8'h39, 8'h93};
        logic [3:0] mask;
        foreach (pat[p]) begin
            for (int c = 0; c < 4; c++) mask[c] = (pat[p][2*c+:2] == 2'h0);
            wr_reg(8'h12, pat[p]);
            wr_reg(8'h10, 8'h0f);
            // step off the launching edge before the outputs are looked at
            @(negedge clk);
            for (int i = 0; i < 8 * TC && sink_on === 4'hf; i++) @(negedge clk);
            chk("joint start", mask, sink_on);
            repeat (200) @(negedge clk);
            chk("steady sink", mask, sink_on & mask);
            for (int c = 0; c < 4; c++) begin
                if (!mask[c]) chk("dark length", 32'(off_t[pat[p][2*c+:2]] * TC),
                    leds.dark_len[c]);
            end
            @(posedge clk);
            wr_reg(8'h10, 8'h00);
        end
        $display("test blink done");
    endtask
    task automatic test_ontime();
        wr_reg(8'h12, 8'h01);
        for (int oc = 0; oc < 4; oc++) begin
            wr_reg(8'h11, 8'(oc << 6));
            wr_reg(8'h10, 8'h01);
            repeat (320) @(negedge clk);
            chk("lit length", 32'(on_t[oc] * TC), leds.lit_len[0]);
            @(posedge clk);
            wr_reg(8'h10, 8'h00);
        end
        $display("test ontime done");
    endtask
    task automatic test_fade();
        wr_reg(8'h12, 8'h00);
        wr_reg(8'h13, 8'h21);
        wr_reg(8'h10, 8'h01);
        @(negedge clk);
        chk("fade in start", 4'h1, ramp);
        repeat (4 * TC) @(negedge clk);
        chk("fade in held", 4'h1, ramp);
        repeat (3 * TC) @(negedge clk);
        chk("fade in over", 4'h0, ramp);
        @(posedge clk);
        wr_reg(8'h10, 8'h00);
        wr_reg(8'h13, 8'h0f);
        wr_reg(8'h10, 8'h01);
        wr_reg(8'h10, 8'h00);
        @(negedge clk);
        chk("ramp cut", 4'h0, ramp);
        @(posedge clk);
        // fade in code f: 5.5 s is 110 ticks, above the knee
        wr_reg(8'h10, 8'h01);
        @(negedge clk);
        repeat (109 * TC) @(negedge clk);
        chk("long fade held", 4'h1, ramp);
        repeat (TC) @(negedge clk);
        chk("long fade over", 4'h0, ramp);
        @(posedge clk);
        wr_reg(8'h10, 8'h00);
        wr_reg(8'h13, 8'h20);
        wr_reg(8'h12, 8'h01);
        wr_reg(8'h10, 8'h01);
        @(negedge clk);
        // on code still 1.2 s from the on-time test, so allow the long phase
        for (int i = 0; i < 32 * TC && sink_on[0] === 1'b1; i++) @(negedge clk);
        chk("fade out", 4'h1, ramp);
        @(posedge clk);
        wr_reg(8'h10, 8'h00);
        $display("test fade done");
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        ce <= 1'b1;
        @(posedge clk);
        test_regs();
        test_steady();
        test_blink();
        test_ontime();
        test_fade();
        test_done();
    end
    // whole run needs about 2600 cycles
    initial begin
        repeat (6000) @(posedge clk);
        err_count++;
        test_done();
    end
endmodule
